// *** verilog/sdr_regs.sv ***
// register side of the four-channel sigma-delta converter
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"

module sdr_regs
   import sdr_pkg::*;
(
   input  wire logic             CORE_CLK,
   input  wire logic             RST,
   input  wire logic             PSEL,
   input  wire logic             PENABLE,
   input  wire logic             PWRITE,
   input  wire logic [7:0]       PADDR,
   input  wire logic [15:0]      PWDATA,
   output var  logic [15:0]      PRDATA,
   output var  logic             PREADY,
   output var  logic             PSLVERR,
   input  wire logic             SMP_VALID,
   input  wire sdr_sample_t      SMP_DATA,
   output var  logic             SMP_READY,
   output var  logic [1:0]       CONV_CHAN,
   output var  logic             OSC_CLK,
   output var  logic [3:0]       CHAN_IRQ
);

   // address decode shared by reads and writes
   function automatic sdr_reg_t decode(input logic [7:0] a);
      case (a)
         `SDR_OFF_RES0: decode = SDR_REG_RES0;
         `SDR_OFF_RES1: decode = SDR_REG_RES1;
         `SDR_OFF_RES2: decode = SDR_REG_RES2;
         `SDR_OFF_RES3: decode = SDR_REG_RES3;
         `SDR_OFF_CSR:  decode = SDR_REG_CSR;
         `SDR_OFF_DIV:  decode = SDR_REG_DIV;
         default:       decode = SDR_REG_NONE;
      endcase
   endfunction : decode

   // unavailable divide values run at the fastest legal ratio
   function automatic logic [11:0] eff_div(input logic [11:0] d);
      eff_div = (d < `SDR_DIV_MIN) ? `SDR_DIV_MIN : d;
   endfunction : eff_div

   sdr_reg_t    reg_sel;
   logic        acc;
   logic        wr;
   logic        setup;
   logic        wr_csr;
   logic        wr_div;
   logic [11:0] div;
   logic [11:0] next_div;
   logic [11:0] div_cnt;
   logic [11:0] next_div_cnt;
   logic        next_osc;
   logic        restart;
   sdr_sample_t buf_mem [0:`SDR_BUF_DEPTH-1];
   sdr_sample_t next_buf_mem [0:`SDR_BUF_DEPTH-1];
   logic        wr_ptr;
   logic        next_wr_ptr;
   logic        rd_ptr;
   logic        next_rd_ptr;
   logic [1:0]  count;
   logic [1:0]  next_count;
   logic        buf_push;
   logic        buf_pop;
   logic        out_valid;
   sdr_sample_t head;
   logic        keep;
   logic [11:0] result [0:3];
   logic [11:0] next_result [0:3];
   logic [3:0]  sample_ready_flags;
   logic [3:0]  next_ready;
   logic [3:0]  unread;
   logic [3:0]  next_unread;
   logic [3:0]  set_mask;
   logic [3:0]  rd_mask;
   logic        ovr;
   logic        next_ovr;
   sdr_ctrl_t   ctrl;
   sdr_ctrl_t   next_ctrl;
   logic [1:0]  rr_chan;
   logic [1:0]  next_rr_chan;
   logic [15:0] next_prdata;

   // bus phases and decode
   assign reg_sel = decode(PADDR);
   assign setup   = PSEL & ~PENABLE;
   assign acc     = PSEL & PENABLE;
   assign wr      = acc & PWRITE;
   assign wr_csr  = wr & (reg_sel == SDR_REG_CSR);
   assign wr_div  = wr & (reg_sel == SDR_REG_DIV);
   assign PREADY  = 1'b1;
   assign PSLVERR = acc & (reg_sel == SDR_REG_NONE);

   // two-entry sample buffer, drain pauses during a bus setup phase
   assign SMP_READY = (count < 2'(`SDR_BUF_DEPTH));
   assign out_valid = (count != 2'd0);
   assign buf_push  = SMP_VALID & SMP_READY;
   assign buf_pop   = out_valid & ~setup;
   assign head      = buf_mem[rd_ptr];
   always_comb begin
      next_buf_mem = buf_mem;
      next_wr_ptr  = wr_ptr;
      next_rd_ptr  = rd_ptr;
      if (buf_push) begin
         next_buf_mem[wr_ptr] = SMP_DATA;
         next_wr_ptr          = ~wr_ptr;
      end
      if (buf_pop) begin
         next_rd_ptr = ~rd_ptr;
      end
      next_count = count + 2'(buf_push) - 2'(buf_pop);
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
         wr_ptr     <= 1'b0;
         rd_ptr     <= 1'b0;
         count      <= 2'd0;
      end else begin
         buf_mem <= next_buf_mem;
         wr_ptr  <= next_wr_ptr;
         rd_ptr  <= next_rd_ptr;
         count   <= next_count;
      end
   end

   // result store, flags and channel sequencing
   assign keep     = buf_pop & (~ctrl.single_mode | (head.chan == ctrl.single_channel_select));
   assign set_mask = keep ? (4'h1 << head.chan) : 4'h0;
   always_comb begin
      next_result = result;
      rd_mask     = 4'h0;
      if (keep) begin
         next_result[head.chan] = head.value;
      end
      if (acc & ~PWRITE & (reg_sel <= SDR_REG_RES3)) begin
         rd_mask = 4'h1 << reg_sel[1:0];
      end
      // set wins over software clear
      next_ready   = (sample_ready_flags & ~(wr_csr ? ~PWDATA[3:0] : 4'h0)) | set_mask;
      next_unread  = (unread & ~rd_mask) | set_mask;
      next_ovr     = (ovr & ~(wr_csr & ~PWDATA[`SDR_CSR_OVR_BIT])) | ((set_mask & unread) != 4'h0);
      next_ctrl    = ctrl;
      if (wr_csr) begin
         next_ctrl.irq_en                = PWDATA[`SDR_CSR_IRQ_EN_LSB+:4];
         next_ctrl.single_mode           = PWDATA[`SDR_CSR_MODE_BIT];
         next_ctrl.single_channel_select = PWDATA[`SDR_CSR_SEL_LSB+:2];
      end
      next_rr_chan = rr_chan;
      if (buf_pop) begin
         next_rr_chan = head.chan + 2'd1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         for (int i = 0; i < 4; i++) begin
            result[i] <= `SDR_RES_RESET;
         end
         sample_ready_flags <= 4'h0;
         unread             <= 4'h0;
         ovr                <= 1'b0;
         ctrl               <= '0;
         rr_chan            <= 2'd0;
      end else begin
         result             <= next_result;
         sample_ready_flags <= next_ready;
         unread             <= next_unread;
         ovr                <= next_ovr;
         ctrl               <= next_ctrl;
         rr_chan            <= next_rr_chan;
      end
   end

   // channel requested from the modulator and per-channel requests
   assign CONV_CHAN = ctrl.single_mode ? ctrl.single_channel_select : rr_chan;
   assign CHAN_IRQ  = ctrl.irq_en & sample_ready_flags;

   // read data captured in the setup phase
   always_comb begin
      case (reg_sel)
         SDR_REG_RES0: next_prdata = {result[0], 4'h0};
         SDR_REG_RES1: next_prdata = {result[1], 4'h0};
         SDR_REG_RES2: next_prdata = {result[2], 4'h0};
         SDR_REG_RES3: next_prdata = {result[3], 4'h0};
         SDR_REG_CSR:  next_prdata = {2'b00, ovr, 1'b0, ctrl.irq_en, 1'b0, ctrl.single_mode,
                                      ctrl.single_channel_select, sample_ready_flags};
         SDR_REG_DIV:  next_prdata = 16'h0000;
         default:      next_prdata = 16'h0000;
      endcase
      if (!setup || PWRITE) begin
         next_prdata = PRDATA;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         PRDATA <= 16'h0000;
      end else begin
         PRDATA <= next_prdata;
      end
   end

   // oversampling clock divider, half period of div cycles
   assign restart = wr_div & (PWDATA[11:0] != div);
   always_comb begin
      next_div     = div;
      next_div_cnt = div_cnt + 12'd1;
      next_osc     = OSC_CLK;
      if (wr_div) begin
         next_div = PWDATA[11:0];
      end
      if (restart) begin
         next_div_cnt = 12'd0;
         next_osc     = 1'b0;
      end else if (div_cnt >= eff_div(div) - 12'd1) begin
         next_div_cnt = 12'd0;
         next_osc     = ~OSC_CLK;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         div     <= `SDR_DIV_RESET;
         div_cnt <= 12'd0;
         OSC_CLK <= 1'b0;
      end else begin
         div     <= next_div;
         div_cnt <= next_div_cnt;
         OSC_CLK <= next_osc;
      end
   end

   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   AST_DIV_RESET: assert property ($past(RST) |-> div == 12'h005)
      else $error("divider not at reset value");
   AST_DIV_READ_ZERO: assert property (acc & ~PWRITE & (reg_sel == SDR_REG_DIV) |-> PRDATA == 16'h0000)
      else $error("divider read not zero");
   AST_DIV_STORE: assert property (wr_div |=> div == $past(PWDATA[11:0]))
      else $error("divider field not stored");
   AST_OSC_TOGGLE: assert property ((OSC_CLK != $past(OSC_CLK)) && !$past(restart) |->
      $past(div_cnt) == eff_div($past(div)) - 12'd1)
      else $error("oscillator toggled off count");
   AST_RESTART: assert property (restart |=> !OSC_CLK && div_cnt == 12'd0)
      else $error("divider not restarted");
   AST_STORE: assert property (keep |=> result[$past(head.chan)] == $past(head.value)
      && sample_ready_flags[$past(head.chan)])
      else $error("sample not stored");
   AST_SINGLE_HOLD: assert property (buf_pop & ctrl.single_mode & (head.chan != ctrl.single_channel_select)
      |=> result[$past(head.chan)] == $past(result[head.chan]))
      else $error("unselected channel updated");
   AST_OVERRUN: assert property (keep & unread[head.chan] |=> ovr)
      else $error("overrun not flagged");
   AST_RR_NEXT: assert property (buf_pop & ~ctrl.single_mode |=> CONV_CHAN == $past(head.chan) + 2'd1)
      else $error("round robin order broken");
   AST_IRQ: assert property (keep & ctrl.irq_en[head.chan] |=> CHAN_IRQ[$past(head.chan)])
      else $error("channel request missing");
   AST_RES_WRITE: assert property (wr & (reg_sel <= SDR_REG_RES3)
      & ~(keep & (head.chan == reg_sel[1:0]))
      |=> result[$past(reg_sel[1:0])] == $past(result[reg_sel[1:0]]))
      else $error("result register written");
   AST_MODE: assert property (wr_csr |=> ctrl.single_mode == $past(PWDATA[6]))
      else $error("mode bit not taken");

   // read data against the stored registers, unmapped reads refused
   AST_RESULT_RDATA: assert property (acc & ~PWRITE & (reg_sel <= SDR_REG_RES3)
      |-> PRDATA == {result[reg_sel[1:0]], 4'h0})
      else $error("result read data wrong");
   AST_UNMAPPED: assert property (acc & ~PWRITE & (reg_sel == SDR_REG_NONE)
      |-> PSLVERR && PRDATA == 16'h0000)
      else $error("unmapped read not refused");
   AST_CSR_IRQ_READ: assert property (acc & ~PWRITE & (reg_sel == SDR_REG_CSR)
      |-> PRDATA[`SDR_CSR_IRQ_EN_LSB+:4] == ctrl.irq_en)
      else $error("request enables read wrong");

   // software clears of the status flags
   AST_READY_CLEAR: assert property (wr_csr & (set_mask == 4'h0)
      |=> sample_ready_flags == ($past(sample_ready_flags) & $past(PWDATA[3:0])))
      else $error("ready flags clear wrong");
   AST_OVR_CLEAR: assert property (wr_csr & ~PWDATA[`SDR_CSR_OVR_BIT] & ((set_mask & unread) == 4'h0)
      |=> !ovr)
      else $error("overrun not cleared");
   AST_UNREAD_CLEAR: assert property (acc & ~PWRITE & (reg_sel <= SDR_REG_RES3) & (set_mask == 4'h0)
      |=> !unread[$past(reg_sel[1:0])])
      else $error("read mark not cleared");

   // divider count and buffer occupancy bounds
   AST_OSC_HOLD: assert property (~restart & (div_cnt < eff_div(div) - 12'd1)
      |=> OSC_CLK == $past(OSC_CLK))
      else $error("oscillator toggled early");
   AST_DIV_CNT_RANGE: assert property (div_cnt < eff_div(div))
      else $error("divider count out of range");
   AST_BUF_COUNT: assert property (count <= 2'(`SDR_BUF_DEPTH))
      else $error("sample buffer overfilled");

   COV_RR_WRAP: cover property (buf_pop & ~ctrl.single_mode & (head.chan == 2'd3));
   COV_OVERRUN: cover property (keep & unread[head.chan]);
   COV_FULL: cover property (SMP_VALID & ~SMP_READY);
   COV_RESTART: cover property (restart);
   COV_SINGLE_DROP: cover property (buf_pop & ctrl.single_mode & ~keep);

endmodule : sdr_regs
`default_nettype wire

// *** pkg/sdr_consts.svh ***
// constants of the sigma-delta converter register block
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH

`define SDR_OFF_RES0      8'h00
`define SDR_OFF_RES1      8'h08
`define SDR_OFF_RES2      8'h10
`define SDR_OFF_RES3      8'h18
`define SDR_OFF_CSR       8'h20
`define SDR_OFF_DIV       8'h30

`define SDR_DIV_RESET     12'h005
`define SDR_DIV_MIN       12'h002
`define SDR_RES_RESET     12'h000
`define SDR_RES_LSB       4
`define SDR_CSR_OVR_BIT   13
`define SDR_CSR_IRQ_EN_LSB 8
`define SDR_CSR_MODE_BIT  6
`define SDR_CSR_SEL_LSB   4
`define SDR_OSC_MAX_KHZ   2100
`define SDR_BUF_DEPTH     2

`endif

// *** pkg/sdr_pkg.sv ***
// types of the sigma-delta converter register block
`default_nettype none
package sdr_pkg;
   // one sample from the decimation filter
   typedef struct packed {
      logic [1:0]  chan;
      logic [11:0] value;
   } sdr_sample_t;

   // writable control fields of the control/status register
   typedef struct packed {
      logic [3:0] irq_en;
      logic       single_mode;
      logic [1:0] single_channel_select;
   } sdr_ctrl_t;

   // register index decoded from a bus address
   typedef enum logic [2:0] {
      SDR_REG_RES0, SDR_REG_RES1, SDR_REG_RES2, SDR_REG_RES3,
      SDR_REG_CSR, SDR_REG_DIV, SDR_REG_NONE
   } sdr_reg_t;
endpackage : sdr_pkg
`default_nettype wire

// *** verification/sdr_filter_model.sv ***
// behavioural decimation filter facing the sample port
`timescale 1ns/1ps
`default_nettype none

module sdr_filter_model
   import sdr_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        SMP_READY,
   input  wire logic        OSC_CLK,
   output var  logic        SMP_VALID,
   output var  sdr_sample_t SMP_DATA,
   output var  logic [15:0] period,
   output var  logic        hung
);
   logic        osc_q  = 1'b0;
   logic [15:0] cnt    = 16'h0000;

   // idle lines at time zero
   initial begin
      SMP_VALID = 1'b0;
      SMP_DATA  = '0;
      period    = 16'h0000;
      hung      = 1'b0;
   end

   // strobes held until taken, channel and value stepping per sample
   task automatic burst(input logic [1:0] ch, input int num, input logic [11:0] v);
      int i;
      int n;
      @(negedge CORE_CLK);
      SMP_VALID = 1'b1;
      for (i = 0; i < num; i++) begin
         SMP_DATA = '{chan: ch + i[1:0], value: v + 12'(i) * 12'h111};
         n = 0;
         @(posedge CORE_CLK);
         while (SMP_READY !== 1'b1 && n < 50) begin
            n++;
            @(posedge CORE_CLK);
         end
         if (n >= 50) hung = 1'b1;
         @(negedge CORE_CLK);
      end
      SMP_VALID = 1'b0;
      SMP_DATA  = ~SMP_DATA; // released lines show no stale value
   endtask : burst

   // edge spacing of the oversampling clock, in core cycles
   always @(posedge CORE_CLK) begin
      osc_q <= OSC_CLK;
      if (OSC_CLK && !osc_q) begin
         period <= cnt;
         cnt    <= 16'h0001;
      end else cnt <= cnt + 16'h0001;
   end
endmodule : sdr_filter_model
`default_nettype wire

// *** verification/sdr_regs_tb.sv ***
// self-checking bench of the converter register block
`timescale 1ns/1ps
`default_nettype none

module sdr_regs_tb
   import sdr_pkg::*;
;
   logic        CORE_CLK = 1'b0;
   logic        RST      = 1'b1;
   logic        PSEL     = 1'b0;
   logic        PENABLE  = 1'b0;
   logic        PWRITE   = 1'b0;
   logic [7:0]  PADDR    = 8'h00;
   logic [15:0] PWDATA   = 16'h0000;
   logic [15:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic        SMP_VALID;
   sdr_sample_t SMP_DATA;
   logic        SMP_READY;
   logic [1:0]  CONV_CHAN;
   logic        OSC_CLK;
   logic [3:0]  CHAN_IRQ;
   logic [15:0] period;
   logic        hung;
   logic        saw_full = 1'b0;
   int          fails = 0;
   int          comparisons = 0;

   sdr_regs sdr_regs_inst (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .SMP_VALID(SMP_VALID), .SMP_DATA(SMP_DATA), .SMP_READY(SMP_READY), .CONV_CHAN(CONV_CHAN),
      .OSC_CLK(OSC_CLK), .CHAN_IRQ(CHAN_IRQ));
   sdr_filter_model sdr_filter_model_inst (.CORE_CLK(CORE_CLK), .SMP_READY(SMP_READY), .OSC_CLK(OSC_CLK),
      .SMP_VALID(SMP_VALID), .SMP_DATA(SMP_DATA), .period(period), .hung(hung));

   // clock and full-buffer watch
   initial forever #5 CORE_CLK = ~CORE_CLK;
   always @(posedge CORE_CLK) if (SMP_READY === 1'b0) saw_full <= 1'b1;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one bus transfer, setup then access, answer taken at the access edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic err);
      @(negedge CORE_CLK);
      PSEL   = 1'b1;
      PWRITE = wr;
      PADDR  = a;
      PWDATA = d;
      @(negedge CORE_CLK);
      PENABLE = 1'b1;
      @(posedge CORE_CLK);
      q   = PRDATA;
      err = PSLVERR;
      @(negedge CORE_CLK);
      PSEL    = 1'b0;
      PENABLE = 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      chk({15'h0000, e}, 16'h0000);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] q;
      logic        e;
      apb(1'b0, a, 16'h0000, q, e);
      chk(q, exp);
      chk({15'h0000, e}, 16'h0000);
   endtask : rd_chk

   // reset values, unmapped offset, default divider
   task automatic t_reset();
      logic [15:0] q;
      logic        e;
      for (int i = 0; i < 4; i++) rd_chk(8'(i * 8), 16'h0000);
      rd_chk(8'h20, 16'h0000);
      rd_chk(8'h30, 16'h0000);
      apb(1'b0, 8'h04, 16'h0000, q, e);
      chk({15'h0000, e}, 16'h0001);
      chk(period, 16'h000a);
   endtask : t_reset

   // two rounds back to back while bus setups stall the drain
   task automatic t_stream();
      logic [15:0] q;
      logic        e;
      fork
         sdr_filter_model_inst.burst(2'd0, 8, 12'h100);
         repeat (6) apb(1'b0, 8'h20, 16'h0000, q, e);
      join
      repeat (3) @(negedge CORE_CLK);
      chk({15'h0000, saw_full}, 16'h0001);
      chk({15'h0000, hung}, 16'h0000);
      chk({14'h0000, CONV_CHAN}, 16'h0000);
      rd_chk(8'h20, 16'h200f);
      for (int n = 0; n < 4; n++) rd_chk(8'(n * 8), {12'h544 + 12'(n) * 12'h111, 4'h0});
   endtask : t_stream

   // flag clearing, request enables, result writes ignored
   task automatic t_flags();
      wr(8'h20, 16'h0f0a);
      rd_chk(8'h20, 16'h0f0a);
      chk({12'h000, CHAN_IRQ}, 16'h000a);
      wr(8'h20, 16'h2f0f);
      rd_chk(8'h20, 16'h0f0a);
      wr(8'h08, 16'hffff);
      rd_chk(8'h08, 16'h6550);
      wr(8'h20, 16'h0000);
      chk({12'h000, CHAN_IRQ}, 16'h0000);
   endtask : t_flags

   // single-channel mode drops other channels
   task automatic t_single();
      wr(8'h20, 16'h0460);
      chk({14'h0000, CONV_CHAN}, 16'h0002);
      sdr_filter_model_inst.burst(2'd1, 1, 12'habc);
      repeat (3) @(negedge CORE_CLK);
      rd_chk(8'h08, 16'h6550);
      sdr_filter_model_inst.burst(2'd2, 1, 12'h7e5);
      repeat (3) @(negedge CORE_CLK);
      rd_chk(8'h10, 16'h7e50);
      rd_chk(8'h20, 16'h0464);
      chk({12'h000, CHAN_IRQ}, 16'h0004);
      chk({15'h0000, hung}, 16'h0000);
   endtask : t_single

   // divider at a divide of 24 and at full scale
   task automatic t_div();
      wr(8'h30, 16'h0018);
      rd_chk(8'h30, 16'h0000);
      repeat (150) @(negedge CORE_CLK);
      chk(period, 16'h0030);
      wr(8'h30, 16'h0fff);
      repeat (3 * 8190 + 20) @(negedge CORE_CLK);
      chk(period, 16'h1ffe);
   endtask : t_div

   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize

   // hang guard
   initial begin
      #1000000;
      fails++;
      summarize();
   end

   // main sequence
   initial begin
      repeat (16) @(negedge CORE_CLK);
      RST = 1'b0;
      t_reset();
      t_stream();
      t_flags();
      t_single();
      t_div();
      summarize();
   end
endmodule : sdr_regs_tb
`default_nettype wire
